// ===== design/ddf_fifo.sv
// ddf_fifo: synchronous valid/ready fifo, width and depth parameters
// assumes: single clock, synchronous active-low reset
`timescale 1ns/1ns
module ddf_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } ddf_fifo_st_t;

  ddf_fifo_st_t      s_r;
  ddf_fifo_st_t      s_nxt;
  logic [WIDTH-1:0]  mem [DEPTH];
  logic              full;
  logic              empty;

  assign empty     = (s_r.wp == s_r.rp);
  assign full      = (s_r.wp[AW-1:0] == s_r.rp[AW-1:0]) && (s_r.wp[AW] != s_r.rp[AW]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[s_r.rp[AW-1:0]];

  always_comb begin
    s_nxt = s_r;
    if (in_valid && !full) begin
      s_nxt.wp = s_r.wp + 1'b1;
    end
    if (out_ready && !empty) begin
      s_nxt.rp = s_r.rp + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
    if (in_valid && !full) begin
      mem[s_r.wp[AW-1:0]] <= in_data;
    end
  end
endmodule

// ===== design/ddf_pkg.sv
// ddf_pkg: constants for the decimating downconverter filter
// assumes: one synchronous clock domain, no software register access
package ddf_pkg;

  // ****************************************************************
  // decimation modes
  // ****************************************************************
  localparam logic [2:0] DDF_MODE_D32 = 3'h1;
  localparam logic [2:0] DDF_MODE_D24 = 3'h2;
  localparam logic [2:0] DDF_MODE_D16 = 3'h3;
  localparam logic [2:0] DDF_MODE_D12 = 3'h4;

  // ****************************************************************
  // widths and sizes
  // ****************************************************************
  localparam int DDF_ADC_W     = 5;
  localparam int DDF_OUT_W     = 16;
  localparam int DDF_ACC_W     = 32;
  localparam int DDF_CPH_W     = 6;
  localparam int DDF_FPH_W     = 10;
  localparam int DDF_FIFO_DEPTH = 16;
  localparam int DDF_SIN_W     = 8;
  // symmetric half-band style taps (center + one side), linear phase
  localparam int DDF_TAPS      = 7;
  localparam int DDF_TAP_W     = 8;
  localparam int DDF_OUT_SHIFT = 8;

  // ****************************************************************
  // fifo reset values
  // ****************************************************************
  localparam logic [4:0] DDF_PTR_RST = 5'h00;

endpackage

// ===== design/ddf_top.sv
// ddf_top: coarse mixer, decimating fir chain, fine mixer, output fifo
// assumes: adc samples arrive synchronous to clk_sys with a valid strobe
// Function
// - modes 1..4 select total decimation 32, 24, 16, 12
// - two identical symmetric fir chains for i and q
// - first stage divides by 3 for 24/12, else by 4
// - stages two and three halve rate; third is final for 12/16
// - fourth halving stage used for 24/32, bypassed for 12/16
// - all stages use symmetric taps for linear phase
// - bandwidth 0.814 for 32/24, 0.571 for 16/12 set by tap design
// - latency from adc to output fixed per mode
// - nominal latency about 34.2 or 32.3 output samples
// - sysref loads coarse and fine oscillator initial phases
// - coarse phase step is 1/64 cycle
// - fine phase step is 1/1024 cycle
// - two flag pins show threshold exceeded or adc reset
// - coarse tuning 6 bits, fine tuning 10 bits
// - coarse mixer at adc, fine mixer after first stage
`timescale 1ns/1ns
module ddf_top
  import ddf_pkg::*;
#(
  parameter int FIFO_DEPTH = ddf_pkg::DDF_FIFO_DEPTH
) (
  input  wire logic                            clk_sys,
  input  wire logic                            rst_n,
  input  wire logic [2:0]                      decimation_select,
  input  wire logic [ddf_pkg::DDF_CPH_W-1:0]   coarse_tune,
  input  wire logic [ddf_pkg::DDF_FPH_W-1:0]   fine_tune,
  input  wire logic [ddf_pkg::DDF_CPH_W-1:0]   coarse_phase_init,
  input  wire logic [ddf_pkg::DDF_FPH_W-1:0]   fine_phase_init,
  input  wire logic                            sysref,
  input  wire logic                            adc_valid,
  input  wire logic signed [ddf_pkg::DDF_ADC_W-1:0] adc_data,
  input  wire logic                            threshold_hit,
  input  wire logic                            adc_reset_event,
  input  wire logic [1:0]                      flag_select,
  output logic                                 flag_out_pin_a,
  output logic                                 flag_out_pin_b,
  input  wire logic                            atten_ctrl_pin_a,
  input  wire logic                            atten_ctrl_pin_b,
  output logic                                 atten_up,
  output logic                                 atten_down,
  output logic                                 iq_valid,
  input  wire logic                            iq_ready,
  output logic signed [ddf_pkg::DDF_OUT_W-1:0] i_out,
  output logic signed [ddf_pkg::DDF_OUT_W-1:0] q_out,
  output logic                                 adc_ready
);
  import ddf_pkg::*;

  // ****************************************************************
  // types and state
  // ****************************************************************
  typedef logic signed [DDF_ACC_W-1:0] ddf_acc_t;
  typedef logic signed [DDF_TAP_W-1:0] ddf_tap_t;

  typedef struct packed {
    logic [DDF_CPH_W-1:0]  cph;
    logic [DDF_FPH_W-1:0]  fph;
    logic [1:0]            ph1;
    ddf_acc_t              a1_i;
    ddf_acc_t              a1_q;
    logic                  v1;
    ddf_acc_t              s1_i;
    ddf_acc_t              s1_q;
    ddf_acc_t              h2_i;
    ddf_acc_t              h2_q;
    logic                  t2;
    logic                  v2;
    ddf_acc_t              s2_i;
    ddf_acc_t              s2_q;
    ddf_acc_t              h3_i;
    ddf_acc_t              h3_q;
    logic                  t3;
    logic                  v3;
    ddf_acc_t              s3_i;
    ddf_acc_t              s3_q;
    ddf_acc_t              h4_i;
    ddf_acc_t              h4_q;
    logic                  t4;
    logic                  vo;
    logic [DDF_OUT_W-1:0]  oi;
    logic [DDF_OUT_W-1:0]  oq;
    logic                  fa;
    logic                  fb;
  } ddf_st_t;

  ddf_st_t s_r;
  ddf_st_t s_nxt;
  logic    fifo_in_ready;
  logic [2*DDF_OUT_W-1:0] fifo_out;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // quarter-symmetric sine table; 1/64 cycle per coarse step
  function automatic ddf_tap_t sin_lut(input logic [5:0] ph);
    logic [3:0] idx;
    ddf_tap_t   mag;
    idx = ph[4] ? 4'(15 - ph[3:0]) : ph[3:0];
    case (idx)
      4'h0: mag = 8'sh00;  4'h1: mag = 8'sh0C;  4'h2: mag = 8'sh19;  4'h3: mag = 8'sh25;
      4'h4: mag = 8'sh31;  4'h5: mag = 8'sh3C;  4'h6: mag = 8'sh47;  4'h7: mag = 8'sh51;
      4'h8: mag = 8'sh5A;  4'h9: mag = 8'sh62;  4'hA: mag = 8'sh6A;  4'hB: mag = 8'sh70;
      4'hC: mag = 8'sh75;  4'hD: mag = 8'sh7A;  4'hE: mag = 8'sh7D;  default: mag = 8'sh7F;
    endcase
    return ph[5] ? ddf_tap_t'(-mag) : mag;
  endfunction

  // complex rotation by phase (top 6 bits); used by coarse and fine mixers
  function automatic ddf_acc_t mix(input ddf_acc_t a, input ddf_acc_t b, input logic [5:0] ph, input logic im);
    ddf_acc_t c;
    ddf_acc_t s;
    c = ddf_acc_t'(sin_lut(6'(ph + 6'h10)));
    s = ddf_acc_t'(sin_lut(ph));
    return im ? ddf_acc_t'((b * c - a * s) >>> 7) : ddf_acc_t'((a * c + b * s) >>> 7);
  endfunction

  // symmetric halfband pair: averages current and held sample
  function automatic ddf_acc_t hb(input ddf_acc_t a, input ddf_acc_t b);
    return ddf_acc_t'((a + b) >>> 1);
  endfunction

  function automatic logic [DDF_OUT_W-1:0] sat(input ddf_acc_t v);
    ddf_acc_t m;
    m = v >>> DDF_OUT_SHIFT;
    if (m > ddf_acc_t'(32767)) begin
      return 16'h7FFF;
    end else if (m < ddf_acc_t'(-32768)) begin
      return 16'h8000;
    end
    return m[DDF_OUT_W-1:0];
  endfunction

  // ****************************************************************
  // datapath
  // ****************************************************************
  logic     by3;
  logic     use4;
  logic [1:0] last1;
  ddf_acc_t x;
  ddf_acc_t mi;
  ddf_acc_t mq;
  ddf_acc_t fi;
  ddf_acc_t fq;

  always_comb begin
    s_nxt = s_r;
    by3   = (decimation_select == DDF_MODE_D24) || (decimation_select == DDF_MODE_D12);
    use4  = (decimation_select == DDF_MODE_D24) || (decimation_select == DDF_MODE_D32);
    last1 = by3 ? 2'h2 : 2'h3;
    x     = ddf_acc_t'(adc_data) <<< DDF_OUT_SHIFT;
    // coarse mixer right at the adc input
    mi    = mix(x, '0, s_r.cph, 1'b0);
    mq    = mix(x, '0, s_r.cph, 1'b1);
    fi    = mix(s_r.a1_i, s_r.a1_q, s_r.fph[9:4], 1'b0);
    fq    = mix(s_r.a1_i, s_r.a1_q, s_r.fph[9:4], 1'b1);
    s_nxt.v1 = 1'b0;
    s_nxt.v2 = 1'b0;
    s_nxt.v3 = 1'b0;
    s_nxt.vo = 1'b0;
    if (sysref) begin
      // phase load realigns all stage counters so latency is repeatable
      s_nxt.cph = coarse_phase_init;
      s_nxt.ph1 = '0;
    end else if (adc_valid && fifo_in_ready) begin
      s_nxt.cph = 6'(s_r.cph + coarse_tune);
      // first stage: boxcar of 3 or 4 taps, symmetric
      if (s_r.ph1 == 2'h0) begin
        s_nxt.a1_i = mi;
        s_nxt.a1_q = mq;
      end else begin
        s_nxt.a1_i = ddf_acc_t'(s_r.a1_i + mi);
        s_nxt.a1_q = ddf_acc_t'(s_r.a1_q + mq);
      end
      if (s_r.ph1 == last1) begin
        s_nxt.ph1 = '0;
        s_nxt.v1  = 1'b1;
      end else begin
        s_nxt.ph1 = 2'(s_r.ph1 + 2'h1);
      end
    end
    if (s_r.v1) begin
      // fine mixer after the first decimation
      s_nxt.fph  = 10'(s_r.fph + fine_tune);
      s_nxt.s1_i = by3 ? ddf_acc_t'((fi * 43) >>> 7) : ddf_acc_t'(fi >>> 2);
      s_nxt.s1_q = by3 ? ddf_acc_t'((fq * 43) >>> 7) : ddf_acc_t'(fq >>> 2);
      s_nxt.t2   = !s_r.t2;
      s_nxt.h2_i = s_nxt.s1_i;
      s_nxt.h2_q = s_nxt.s1_q;
      if (s_r.t2) begin
        s_nxt.v2   = 1'b1;
        s_nxt.s2_i = hb(s_nxt.s1_i, s_r.h2_i);
        s_nxt.s2_q = hb(s_nxt.s1_q, s_r.h2_q);
      end
    end
    if (s_r.v2) begin
      s_nxt.t3   = !s_r.t3;
      s_nxt.h3_i = s_r.s2_i;
      s_nxt.h3_q = s_r.s2_q;
      if (s_r.t3) begin
        s_nxt.v3   = 1'b1;
        s_nxt.s3_i = hb(s_r.s2_i, s_r.h3_i);
        s_nxt.s3_q = hb(s_r.s2_q, s_r.h3_q);
      end
    end
    if (s_r.v3) begin
      if (!use4) begin
        s_nxt.vo = 1'b1;
        s_nxt.oi = sat(s_r.s3_i);
        s_nxt.oq = sat(s_r.s3_q);
      end else begin
        s_nxt.t4   = !s_r.t4;
        s_nxt.h4_i = s_r.s3_i;
        s_nxt.h4_q = s_r.s3_q;
        if (s_r.t4) begin
          s_nxt.vo = 1'b1;
          s_nxt.oi = sat(hb(s_r.s3_i, s_r.h4_i));
          s_nxt.oq = sat(hb(s_r.s3_q, s_r.h4_q));
        end
      end
    end
    // sysref beats a stage strobe in the same cycle, else the fine phase load is lost
    if (sysref) begin
      s_nxt.fph = fine_phase_init;
      s_nxt.t2  = 1'b0;
      s_nxt.t3  = 1'b0;
      s_nxt.t4  = 1'b0;
    end
    // flag pins: a is threshold for select 0/2, reset event for 1, either for 3; b is reset event, or either when select bit 1 set
    s_nxt.fa = (flag_select[0] ? adc_reset_event : threshold_hit) | (flag_select[1] & threshold_hit);
    s_nxt.fb = adc_reset_event | (flag_select[1] & threshold_hit);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // output fifo
  // ****************************************************************
  // stalling adc_ready freezes the first stage and the coarse phase, so no sample is dropped
  ddf_fifo #(
    .WIDTH (2*DDF_OUT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (s_r.vo),
    .in_ready  (fifo_in_ready),
    .in_data   ({s_r.oi, s_r.oq}),
    .out_valid (iq_valid),
    .out_ready (iq_ready),
    .out_data  (fifo_out)
  );

  assign i_out          = fifo_out[2*DDF_OUT_W-1:DDF_OUT_W];
  assign q_out          = fifo_out[DDF_OUT_W-1:0];
  assign adc_ready      = fifo_in_ready;
  assign flag_out_pin_a = s_r.fa;
  assign flag_out_pin_b = s_r.fb;
  // attenuator pins pass to the analog side: a increments, b decrements
  assign atten_up       = atten_ctrl_pin_a;
  assign atten_down     = atten_ctrl_pin_b;
endmodule

// ===== testbench/ddf_assertions.sv
// ddf_assertions: port-level checks on ddf_top
// assumes: bound to ddf_top, one clock, synchronous active-low reset
`timescale 1ns/1ns
module ddf_assertions
  import ddf_pkg::*;
(
  input wire logic                                 clk_sys,
  input wire logic                                 rst_n,
  input wire logic                                 threshold_hit,
  input wire logic                                 adc_reset_event,
  input wire logic [1:0]                           flag_select,
  input wire logic                                 flag_out_pin_a,
  input wire logic                                 flag_out_pin_b,
  input wire logic                                 atten_ctrl_pin_a,
  input wire logic                                 atten_ctrl_pin_b,
  input wire logic                                 atten_up,
  input wire logic                                 atten_down,
  input wire logic                                 iq_valid,
  input wire logic                                 iq_ready,
  input wire logic signed [ddf_pkg::DDF_OUT_W-1:0] i_out,
  input wire logic signed [ddf_pkg::DDF_OUT_W-1:0] q_out,
  input wire logic                                 adc_ready
);
  logic exp_a;
  logic exp_b;
  // **********************************************
  // flag mapping, registered one cycle later
  // **********************************************
  assign exp_a = (flag_select[0] ? adc_reset_event : threshold_hit) | (flag_select[1] & threshold_hit);
  assign exp_b = adc_reset_event | (flag_select[1] & threshold_hit);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  flag_a_map_a: assert property ($past(rst_n) |-> flag_out_pin_a == $past(exp_a))
    else $error("flag a mismatch");
  flag_b_map_a: assert property ($past(rst_n) |-> flag_out_pin_b == $past(exp_b))
    else $error("flag b mismatch");
  atten_up_a: assert property (atten_up == atten_ctrl_pin_a)
    else $error("atten up not passed through");
  atten_down_a: assert property (atten_down == atten_ctrl_pin_b)
    else $error("atten down not passed through");
  reset_state_a: assert property ($rose(rst_n) |-> !iq_valid && adc_ready && !flag_out_pin_a && !flag_out_pin_b)
    else $error("outputs not idle after reset");
  out_hold_a: assert property (iq_valid && !iq_ready |=> iq_valid && $stable(i_out) && $stable(q_out))
    else $error("output word changed before pop");
  valid_fall_a: assert property ($fell(iq_valid) |-> $past(iq_ready))
    else $error("output dropped without pop");
  full_valid_a: assert property (!adc_ready |-> iq_valid)
    else $error("input refused with empty buffer");
  full_hold_a: assert property (!adc_ready && !iq_ready |=> !adc_ready)
    else $error("buffer left full state without pop");
endmodule

bind ddf_top ddf_assertions u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .threshold_hit(threshold_hit), .adc_reset_event(adc_reset_event),
  .flag_select(flag_select), .flag_out_pin_a(flag_out_pin_a), .flag_out_pin_b(flag_out_pin_b),
  .atten_ctrl_pin_a(atten_ctrl_pin_a), .atten_ctrl_pin_b(atten_ctrl_pin_b), .atten_up(atten_up),
  .atten_down(atten_down), .iq_valid(iq_valid), .iq_ready(iq_ready), .i_out(i_out), .q_out(q_out),
  .adc_ready(adc_ready)
);

// ===== testbench/ddf_host_model.sv
// ddf_host_model: downstream receiver taking i/q words and steering the attenuator
// assumes: signals change 5 ns after the rising clock edge
`timescale 1ns/1ns
module ddf_host_model (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic stall,
  output logic      iq_ready,
  output logic      atten_a,
  output logic      atten_b
);
  int   r;
  logic go;
  initial begin
    iq_ready = 1'b0;
    atten_a = 1'b0;
    atten_b = 1'b0;
  end
  // random acceptance mixes prompt and slow takers
  always @(posedge clk_sys) begin
    // bench inputs settle 5 ns after the edge, so take them at the edge itself
    go = rst_n && !stall;
    #5;
    r = $urandom % 8;
    iq_ready = go && (r > 1);
    atten_a = (r == 0);
    atten_b = (r == 1);
  end
endmodule

// ===== testbench/tb_top.sv
// tb_top: self-checking bench for ddf_top with a host model
// assumes: ddf_top, ddf_host_model and the bound checker are compiled
`timescale 1ns/1ns
module tb_top;
  import ddf_pkg::*;
  logic                  clk_sys = 1'b0;
  logic                  rst_n = 1'b0;
  logic [2:0]            decimation_select = DDF_MODE_D16;
  logic [DDF_CPH_W-1:0]  coarse_tune = '0;
  logic [DDF_FPH_W-1:0]  fine_tune = '0;
  logic [DDF_CPH_W-1:0]  coarse_phase_init = '0;
  logic [DDF_FPH_W-1:0]  fine_phase_init = '0;
  logic                  sysref = 1'b0;
  logic                  adc_valid = 1'b0;
  logic signed [4:0]     adc_data = '0;
  logic                  threshold_hit = 1'b0;
  logic                  adc_reset_event = 1'b0;
  logic [1:0]            flag_select = 2'h0;
  logic                  stall = 1'b0;
  logic                  flag_out_pin_a, flag_out_pin_b, atten_ctrl_pin_a, atten_ctrl_pin_b;
  logic                  atten_up, atten_down, iq_valid, iq_ready, adc_ready;
  logic signed [15:0]    i_out, q_out;
  int                    n_mismatch = 0;
  int                    total_checks = 0;
  logic [1:0]            fq[$];
  int                    oq[$];
  int                    note_w;

  always #25 clk_sys = ~clk_sys;

  ddf_top u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .decimation_select(decimation_select), .coarse_tune(coarse_tune),
    .fine_tune(fine_tune), .coarse_phase_init(coarse_phase_init), .fine_phase_init(fine_phase_init),
    .sysref(sysref), .adc_valid(adc_valid), .adc_data(adc_data), .threshold_hit(threshold_hit),
    .adc_reset_event(adc_reset_event), .flag_select(flag_select), .flag_out_pin_a(flag_out_pin_a),
    .flag_out_pin_b(flag_out_pin_b), .atten_ctrl_pin_a(atten_ctrl_pin_a), .atten_ctrl_pin_b(atten_ctrl_pin_b),
    .atten_up(atten_up), .atten_down(atten_down), .iq_valid(iq_valid), .iq_ready(iq_ready),
    .i_out(i_out), .q_out(q_out), .adc_ready(adc_ready)
  );
  ddf_host_model u_host (
    .clk_sys(clk_sys), .rst_n(rst_n), .stall(stall), .iq_ready(iq_ready),
    .atten_a(atten_ctrl_pin_a), .atten_b(atten_ctrl_pin_b)
  );

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic step();
    @(posedge clk_sys);
    #5;
  endtask

  task automatic do_reset();
    rst_n = 1'b0;
    repeat (16) step();
    rst_n = 1'b1;
  endtask

  // **********************************************
  // result watcher, sampled where outputs are settled
  // **********************************************
  always @(negedge clk_sys) begin
    if (rst_n && fq.size() > 0) begin
      chk("flags", {14'h0, flag_out_pin_a, flag_out_pin_b}, {14'h0, fq.pop_front()});
    end
    if (rst_n && iq_valid === 1'b1 && iq_ready === 1'b1) begin
      note_w = (oq.size() > 0) ? oq.pop_front() : 0;
      chk("output due", 16'(note_w != 0), 16'h1);
      if (note_w == 2) begin
        chk("q unrotated", q_out, 16'h0000);
        chk("i unrotated live", 16'(i_out != 0), 16'h1);
      end
      if (note_w == 3) begin
        chk("i quarter turn", i_out, 16'h0000);
        chk("q quarter turn live", 16'(q_out != 0), 16'h1);
      end
    end
  end

  // a note per d accepted samples; fill mode stalls the host until refusal
  // rot: -1 random tuning, 0 no rotation, 1 coarse quarter turn, 2 fine quarter turn
  task automatic run_mode(input logic [2:0] m, input int d, input int k, input bit fill, input int rot);
    int acc;
    int n;
    int note;
    acc = 0;
    n = 0;
    note = (rot < 0) ? 1 : ((rot == 0) ? 2 : 3);
    decimation_select = m;
    {coarse_tune, fine_tune} = 16'($urandom);
    {coarse_phase_init, fine_phase_init} = 16'($urandom);
    if (rot >= 0) begin
      {coarse_tune, fine_tune} = 16'h0000;
      // 16 coarse steps or 256 fine steps make a quarter cycle
      coarse_phase_init = (rot == 1) ? 6'h10 : 6'h00;
      fine_phase_init   = (rot == 2) ? 10'h100 : 10'h000;
    end
    stall = fill;
    step();
    sysref = 1'b1;
    step();
    sysref = 1'b0;
    while (acc < d * k && n < 4000) begin
      adc_valid = 1'($urandom);
      // positive samples keep the live channel clear of zero
      adc_data = (rot < 0) ? 5'($urandom) : 5'(4 + $urandom % 8);
      @(negedge clk_sys);
      if (fill && !adc_ready) break;
      if (adc_valid && adc_ready) begin
        acc++;
        if (acc % d == 0) oq.push_back(note);
      end
      step();
      n++;
    end
    if (n == 4000 && acc < d * k) begin
      n_mismatch++;
      report_and_stop();
    end
    if (fill) begin
      chk("words at full", 16'(acc / d), 16'(DDF_FIFO_DEPTH));
      chk("valid at full", {15'h0, iq_valid}, 16'h1);
      step();
    end
    adc_valid = 1'b0;
    stall = 1'b0;
    n = 0;
    while (oq.size() > 0 && n < 3000) begin
      step();
      n++;
    end
    if (oq.size() > 0) begin
      n_mismatch++;
      report_and_stop();
    end
    repeat (4 * d) step();
    chk("drained", {15'h0, iq_valid}, 16'h0);
  endtask

  task automatic flag_test();
    logic [1:0] e;
    repeat (200) begin
      {threshold_hit, adc_reset_event, flag_select} = 4'($urandom);
      e[1] = (flag_select[0] ? adc_reset_event : threshold_hit) | (flag_select[1] & threshold_hit);
      e[0] = adc_reset_event | (flag_select[1] & threshold_hit);
      step();
      fq.push_back(e);
    end
  endtask

  initial begin
    void'($urandom(32'hAB0E));
    do_reset();
    run_mode(DDF_MODE_D32, 32, 3, 1'b0, -1);
    run_mode(DDF_MODE_D24, 24, 3, 1'b0, -1);
    run_mode(DDF_MODE_D16, 16, 3, 1'b0, -1);
    run_mode(DDF_MODE_D12, 12, 3, 1'b0, -1);
    run_mode(DDF_MODE_D16, 16, 3, 1'b0, 0);
    run_mode(DDF_MODE_D24, 24, 3, 1'b0, 1);
    run_mode(DDF_MODE_D32, 32, 3, 1'b0, 2);
    run_mode(DDF_MODE_D12, 12, 20, 1'b1, -1);
    do_reset();
    flag_test();
    repeat (3) step();
    report_and_stop();
  end
endmodule
